/* File: tcc_pkg.sv */
package tcc_pkg;

	// Register locations on the 8-bit I/O port.
	localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
	localparam logic [3:0] ADDR_CNT_LO   = 4'h2;
	localparam logic [3:0] ADDR_CNT_HI   = 4'h3;
	localparam logic [3:0] ADDR_CAP_LO   = 4'h4;
	localparam logic [3:0] ADDR_CAP_HI   = 4'h5;
	localparam logic [3:0] ADDR_CMPA_LO  = 4'h6;
	localparam logic [3:0] ADDR_CMPA_HI  = 4'h7;
	localparam logic [3:0] ADDR_FLAGS    = 4'h8;
	localparam logic [3:0] ADDR_MASK     = 4'h9;
	localparam logic [3:0] ADDR_ACMP     = 4'hA;

	// Field positions.
	localparam int CTRL_B_NF_BIT    = 7;
	localparam int CTRL_B_EDGE_BIT  = 6;
	localparam int CTRL_B_RTG_BIT   = 5;
	localparam int CTRL_B_WGM_HI    = 4;
	localparam int CTRL_B_WGM_LO    = 3;
	localparam int CTRL_B_CS_HI     = 2;
	localparam int CTRL_A_WGM_HI    = 1;
	localparam int FLAG_OVF_BIT     = 0;
	localparam int FLAG_CAP_BIT     = 5;
	localparam int ACMP_SEL_BIT     = 0;

	// Clock select codes.
	localparam logic [2:0] CS_STOP      = 3'h0;
	localparam logic [2:0] CS_SYS       = 3'h1;
	localparam logic [2:0] CS_TAP_BASE  = 3'h2;
	localparam logic [2:0] CS_EXT_FALL  = 3'h6;
	localparam logic [2:0] CS_EXT_RISE  = 3'h7;

	// Count values and reset values.
	localparam logic [15:0] TOP_8BIT    = 16'h00FF;
	localparam logic [15:0] TOP_9BIT    = 16'h01FF;
	localparam logic [15:0] TOP_10BIT   = 16'h03FF;
	localparam logic [15:0] TOP_MAX     = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [15:0] CNT_ONE     = 16'h0001;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [3:0]  FILT_RESET  = 4'h0;
	localparam logic [3:0]  FILT_ALL1   = 4'hF;

	// Noise filter length in system clock samples.
	localparam int FILTER_SAMPLES = 4;

	// Source of the count top value.
	typedef enum logic [4:0] {
		TCC_TOP_MAX  = 5'b00001,
		TCC_TOP_8    = 5'b00010,
		TCC_TOP_9    = 5'b00100,
		TCC_TOP_10   = 5'b01000,
		TCC_TOP_CMPA = 5'b10000
	} tcc_topsel_t;

	// Count direction, one-hot.
	typedef enum logic [1:0] {
		TCC_DIR_UP   = 2'b01,
		TCC_DIR_DOWN = 2'b10
	} tcc_dir_t;

endpackage

/* File: tcc_timer16.sv */
`timescale 1ns/1ns
module tcc_timer16 (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Processor I/O port
	input  wire logic [3:0] io_addr_i,
	input  wire logic       io_wr_i,
	input  wire logic       io_rd_i,
	input  wire logic [7:0] io_wdata_i,
	output logic      [7:0] io_rdata_o,
	// Interrupt service acknowledges
	input  wire logic       capture_irq_ack_i,
	input  wire logic       overflow_irq_ack_i,
	// Tick sources
	input  wire logic [3:0] prescale_taps_i,
	input  wire logic       external_tick_pin_i,
	// Capture sources
	input  wire logic       capture_pin_i,
	input  wire logic       comparator_out_i,
	// Status outputs
	output logic            capture_irq_o,
	output logic            overflow_irq_o,
	output logic            top_o,
	output logic            bottom_o
);

	logic [7:0]  ctrl_a_q, ctrl_b_q, mask_q, acmp_q, temp_q, rdata_q, rdata_d;
	logic [15:0] count_q, capture_q, cmpa_q;
	logic        flag_ovf_q, flag_cap_q;
	tcc_pkg::tcc_dir_t dir_q;
	logic [1:0]  ext_sync_q, cap_sync_q, acmp_sync_q;
	logic        ext_prev_q;
	logic [3:0]  filt_sh_q, filt_win;
	logic        filt_out_q, edge_prev_q;
	logic [3:0]  mode;
	logic [2:0]  cs;
	logic        tick, cap_src, edge_in, cap_evt, retrigger_request, top_hit, bottom_hit;
	logic        cnt_lo_wr, cap_lo_wr, dual, icr_top;
	logic [15:0] top_val;

	function automatic tcc_pkg::tcc_topsel_t f_topsel(input logic [3:0] m);
		case (m)
			4'h1, 4'h5:        f_topsel = tcc_pkg::TCC_TOP_8;
			4'h2, 4'h6:        f_topsel = tcc_pkg::TCC_TOP_9;
			4'h3, 4'h7:        f_topsel = tcc_pkg::TCC_TOP_10;
			4'h4, 4'h9, 4'hB, 4'hF: f_topsel = tcc_pkg::TCC_TOP_CMPA;
			default:           f_topsel = tcc_pkg::TCC_TOP_MAX;
		endcase
	endfunction

	// Modes where the capture register defines top.
	function automatic logic f_icr_top(input logic [3:0] m);
		f_icr_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
	endfunction

	// Modes that count up then down.
	function automatic logic f_dual(input logic [3:0] m);
		f_dual = (m >= 4'h8 && m <= 4'hB) || (m >= 4'h1 && m <= 4'h3);
	endfunction

	assign mode    = {ctrl_b_q[tcc_pkg::CTRL_B_WGM_HI:tcc_pkg::CTRL_B_WGM_LO],
	                  ctrl_a_q[tcc_pkg::CTRL_A_WGM_HI:0]};
	assign cs      = ctrl_b_q[tcc_pkg::CTRL_B_CS_HI:0];
	assign dual    = f_dual(mode);
	assign icr_top = f_icr_top(mode);

	always_comb begin
		if (icr_top) begin
			top_val = capture_q;
		end else begin
			case (f_topsel(mode))
				tcc_pkg::TCC_TOP_8:    top_val = tcc_pkg::TOP_8BIT;
				tcc_pkg::TCC_TOP_9:    top_val = tcc_pkg::TOP_9BIT;
				tcc_pkg::TCC_TOP_10:   top_val = tcc_pkg::TOP_10BIT;
				tcc_pkg::TCC_TOP_CMPA: top_val = cmpa_q;
				default:               top_val = tcc_pkg::TOP_MAX;
			endcase
		end
	end

	// Pin inputs pass two flip-flops before anything looks at them.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ext_sync_q  <= 2'b00;
			cap_sync_q  <= 2'b00;
			acmp_sync_q <= 2'b00;
			ext_prev_q  <= 1'b0;
		end else begin
			ext_sync_q  <= {ext_sync_q[0], external_tick_pin_i};
			cap_sync_q  <= {cap_sync_q[0], capture_pin_i};
			acmp_sync_q <= {acmp_sync_q[0], comparator_out_i};
			ext_prev_q  <= ext_sync_q[1];
		end
	end

	always_comb begin
		if (cs == tcc_pkg::CS_STOP) begin
			tick = 1'b0;
		end else if (cs == tcc_pkg::CS_SYS) begin
			tick = 1'b1;
		end else if (cs == tcc_pkg::CS_EXT_FALL) begin
			tick = ext_prev_q && !ext_sync_q[1];
		end else if (cs == tcc_pkg::CS_EXT_RISE) begin
			tick = !ext_prev_q && ext_sync_q[1];
		end else begin
			tick = prescale_taps_i[2'(cs - tcc_pkg::CS_TAP_BASE)];
		end
	end

	// Switching the source may itself look like an edge; software clears the flag afterwards.
	assign cap_src = acmp_q[tcc_pkg::ACMP_SEL_BIT] ? acmp_sync_q[1] : cap_sync_q[1];
	// The newest sample joins the three held ones, so the output moves four clocks after its input.
	assign filt_win = {filt_sh_q[2:0], cap_src};

	// The filter runs on every system clock, so the prescaler never slows it.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			filt_sh_q  <= tcc_pkg::FILT_RESET;
			filt_out_q <= 1'b0;
		end else begin
			filt_sh_q <= filt_win;
			if (filt_win == tcc_pkg::FILT_ALL1) begin
				filt_out_q <= 1'b1;
			end else if (filt_win == tcc_pkg::FILT_RESET) begin
				filt_out_q <= 1'b0;
			end
		end
	end

	assign edge_in = ctrl_b_q[tcc_pkg::CTRL_B_NF_BIT] ? filt_out_q : cap_src;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			edge_prev_q <= 1'b0;
		end else begin
			edge_prev_q <= edge_in;
		end
	end

	// Detector is gated off while the capture register serves as top.
	assign cap_evt = !icr_top && (edge_prev_q != edge_in) &&
	                 (edge_in == ctrl_b_q[tcc_pkg::CTRL_B_EDGE_BIT]);
	assign retrigger_request        = cap_evt && ctrl_b_q[tcc_pkg::CTRL_B_RTG_BIT];
	assign top_hit    = (count_q == top_val) || retrigger_request;
	assign bottom_hit = (count_q == tcc_pkg::CNT_ZERO);
	assign top_o      = top_hit;
	assign bottom_o   = bottom_hit;

	assign cnt_lo_wr = io_wr_i && (io_addr_i == tcc_pkg::ADDR_CNT_LO);
	assign cap_lo_wr = io_wr_i && (io_addr_i == tcc_pkg::ADDR_CAP_LO) && icr_top;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl_a_q <= tcc_pkg::BYTE_RESET;
			ctrl_b_q <= tcc_pkg::BYTE_RESET;
			mask_q   <= tcc_pkg::BYTE_RESET;
			acmp_q   <= tcc_pkg::BYTE_RESET;
		end else if (io_wr_i) begin
			if (io_addr_i == tcc_pkg::ADDR_CTRL_A) begin
				ctrl_a_q <= io_wdata_i;
			end else if (io_addr_i == tcc_pkg::ADDR_CTRL_B) begin
				ctrl_b_q <= io_wdata_i;
			end else if (io_addr_i == tcc_pkg::ADDR_MASK) begin
				mask_q <= io_wdata_i;
			end else if (io_addr_i == tcc_pkg::ADDR_ACMP) begin
				acmp_q <= io_wdata_i;
			end
		end
	end

	// One holding register shared by all sixteen-bit locations.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			temp_q <= tcc_pkg::BYTE_RESET;
		end else if (io_wr_i && (io_addr_i == tcc_pkg::ADDR_CNT_HI ||
		             io_addr_i == tcc_pkg::ADDR_CAP_HI || io_addr_i == tcc_pkg::ADDR_CMPA_HI)) begin
			temp_q <= io_wdata_i;
		end else if (io_rd_i && io_addr_i == tcc_pkg::ADDR_CNT_LO) begin
			temp_q <= count_q[15:8];
		end else if (io_rd_i && io_addr_i == tcc_pkg::ADDR_CAP_LO) begin
			temp_q <= capture_q[15:8];
		end
		// Low-byte writes leave the holding register untouched.
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cmpa_q <= tcc_pkg::TOP_MAX;
		end else if (io_wr_i && io_addr_i == tcc_pkg::ADDR_CMPA_LO) begin
			cmpa_q <= {temp_q, io_wdata_i};
		end
	end

	// Count and direction.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			count_q <= tcc_pkg::CNT_ZERO;
			dir_q   <= tcc_pkg::TCC_DIR_UP;
		end else if (cnt_lo_wr) begin
			count_q <= {temp_q, io_wdata_i};
		end else if (tick) begin
			if (!dual) begin
				count_q <= top_hit ? tcc_pkg::CNT_ZERO : count_q + tcc_pkg::CNT_ONE;
			end else begin
				case (dir_q)
					tcc_pkg::TCC_DIR_UP: begin
						if (top_hit) begin
							dir_q   <= tcc_pkg::TCC_DIR_DOWN;
							count_q <= count_q - tcc_pkg::CNT_ONE;
						end else begin
							count_q <= count_q + tcc_pkg::CNT_ONE;
						end
					end
					default: begin
						if (bottom_hit) begin
							dir_q   <= tcc_pkg::TCC_DIR_UP;
							count_q <= count_q + tcc_pkg::CNT_ONE;
						end else begin
							count_q <= count_q - tcc_pkg::CNT_ONE;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			capture_q <= tcc_pkg::CNT_ZERO;
		end else if (cap_lo_wr) begin
			capture_q <= {temp_q, io_wdata_i};
		end else if (cap_evt) begin
			capture_q <= count_q;
		end
	end

	// Flags: a set in the same cycle as a clear wins.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			flag_cap_q <= 1'b0;
			flag_ovf_q <= 1'b0;
		end else begin
			if (cap_evt) begin
				flag_cap_q <= 1'b1;
			end else if (capture_irq_ack_i ||
			             (io_wr_i && io_addr_i == tcc_pkg::ADDR_FLAGS && io_wdata_i[tcc_pkg::FLAG_CAP_BIT])) begin
				flag_cap_q <= 1'b0;
			end
			if (tick && !cnt_lo_wr && ((!dual && top_hit) ||
			    (dual && dir_q == tcc_pkg::TCC_DIR_DOWN && bottom_hit))) begin
				flag_ovf_q <= 1'b1;
			end else if (overflow_irq_ack_i ||
			             (io_wr_i && io_addr_i == tcc_pkg::ADDR_FLAGS && io_wdata_i[tcc_pkg::FLAG_OVF_BIT])) begin
				flag_ovf_q <= 1'b0;
			end
		end
	end

	assign capture_irq_o  = flag_cap_q && mask_q[tcc_pkg::FLAG_CAP_BIT];
	assign overflow_irq_o = flag_ovf_q && mask_q[tcc_pkg::FLAG_OVF_BIT];

	always_comb begin
		rdata_d = tcc_pkg::BYTE_RESET;
		if (io_addr_i == tcc_pkg::ADDR_CTRL_A) begin
			rdata_d = ctrl_a_q;
		end else if (io_addr_i == tcc_pkg::ADDR_CTRL_B) begin
			rdata_d = ctrl_b_q;
		end else if (io_addr_i == tcc_pkg::ADDR_CNT_LO) begin
			rdata_d = count_q[7:0];
		end else if (io_addr_i == tcc_pkg::ADDR_CNT_HI || io_addr_i == tcc_pkg::ADDR_CAP_HI) begin
			rdata_d = temp_q;
		end else if (io_addr_i == tcc_pkg::ADDR_CAP_LO) begin
			rdata_d = capture_q[7:0];
		end else if (io_addr_i == tcc_pkg::ADDR_CMPA_LO) begin
			rdata_d = cmpa_q[7:0];
		end else if (io_addr_i == tcc_pkg::ADDR_CMPA_HI) begin
			rdata_d = cmpa_q[15:8];
		end else if (io_addr_i == tcc_pkg::ADDR_FLAGS) begin
			rdata_d[tcc_pkg::FLAG_CAP_BIT] = flag_cap_q;
			rdata_d[tcc_pkg::FLAG_OVF_BIT] = flag_ovf_q;
		end else if (io_addr_i == tcc_pkg::ADDR_MASK) begin
			rdata_d = mask_q;
		end else if (io_addr_i == tcc_pkg::ADDR_ACMP) begin
			rdata_d = acmp_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rdata_q <= tcc_pkg::BYTE_RESET;
		end else if (io_rd_i) begin
			rdata_q <= rdata_d;
		end
	end

	assign io_rdata_o = rdata_q;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	property p_stopped;
		(cs == tcc_pkg::CS_STOP) && !cnt_lo_wr |=> $stable(count_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("Counter moved with no tick source.");

	property p_write_load;
		cnt_lo_wr && tick |=> count_q == {$past(temp_q), $past(io_wdata_i)};
	endproperty
	a_write_load: assert property (p_write_load) else $error("Count write lost to counting.");

	property p_temp_keep;
		cnt_lo_wr && !io_rd_i |=> $stable(temp_q);
	endproperty
	a_temp_keep: assert property (p_temp_keep) else $error("Holding register changed on low write.");

	property p_low_read;
		io_rd_i && io_addr_i == tcc_pkg::ADDR_CNT_LO && !io_wr_i |=> temp_q == $past(count_q[15:8]);
	endproperty
	a_low_read: assert property (p_low_read) else $error("Low read did not latch high byte.");

	property p_capture;
		cap_evt && !cap_lo_wr |=> capture_q == $past(count_q) && flag_cap_q;
	endproperty
	a_capture: assert property (p_capture) else $error("Capture value or flag wrong.");

	property p_up_step;
		tick && !cnt_lo_wr && !dual && !top_hit |=> count_q == $past(count_q) + tcc_pkg::CNT_ONE;
	endproperty
	a_up_step: assert property (p_up_step) else $error("Counter did not step by one.");

	property p_filter;
		ctrl_b_q[tcc_pkg::CTRL_B_NF_BIT] && $rose(filt_out_q) |-> filt_sh_q == tcc_pkg::FILT_ALL1;
	endproperty
	a_filter: assert property (p_filter) else $error("Filter changed before four equal samples.");

	property p_icr_top_quiet;
		icr_top && !cap_lo_wr |=> $stable(capture_q);
	endproperty
	a_icr_top_quiet: assert property (p_icr_top_quiet) else $error("Capture seen in capture-top mode.");

	property p_flag_clear;
		flag_cap_q && !cap_evt && capture_irq_ack_i |=> !flag_cap_q;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("Capture flag not cleared by service.");

	property p_ovf_set;
		tick && !cnt_lo_wr && !dual && top_hit |=> flag_ovf_q && count_q == tcc_pkg::CNT_ZERO;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("Overflow not raised at top.");

	c_capture: cover property (cap_evt ##1 capture_irq_o);
	c_retrigger: cover property (retrigger_request && tick);
	c_dual_turn: cover property (dual && dir_q == tcc_pkg::TCC_DIR_DOWN && bottom_hit && tick);

endmodule

/* File: tcc_cpu_model.sv */
`timescale 1ns/1ns
// Processor side of the register port. Strobes move only at the falling edge
// and are held over exactly one rising edge, so each call is one access.
module tcc_cpu_model (
	// Clock and read return
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] io_rdata_i,
	// Register port drive
	output logic      [3:0] io_addr_o,
	output logic            io_wr_o,
	output logic            io_rd_o,
	output logic      [7:0] io_wdata_o
);
	initial begin
		io_addr_o = 4'hF;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = 8'h00;
	end

	// Idle address and data are inverted so no stale value looks valid.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		io_addr_o = a;
		io_wdata_o = d;
		io_wr_o = 1'b1;
		@(negedge clk_sys_i);
		io_wr_o = 1'b0;
		io_addr_o = ~a;
		io_wdata_o = ~d;
	endtask

	// Read data is registered, so it is taken at the falling edge after the strobe.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk_sys_i);
		io_addr_o = a;
		io_rd_o = 1'b1;
		@(negedge clk_sys_i);
		io_rd_o = 1'b0;
		io_addr_o = ~a;
		d = io_rdata_i;
	endtask
endmodule

/* File: tcc_timer16_tb.sv */
`timescale 1ns/1ns
module tcc_timer16_tb;
	logic        clk_sys_i;
	logic        rst_i;
	logic [3:0]  io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic        cap_ack;
	logic        ovf_ack;
	logic [3:0]  taps;
	logic        ext_pin;
	logic        cap_pin;
	logic        cmp_out;
	logic        cap_irq;
	logic        ovf_irq;
	logic        top;
	logic        bottom;
	logic        saw;
	logic [7:0]  b;
	logic [15:0] v;
	int          mismatches;
	int          cmp_count;
	int          cycles;

	tcc_cpu_model i_cpu (
		.clk_sys_i (clk_sys_i),
		.io_rdata_i(io_rdata),
		.io_addr_o (io_addr),
		.io_wr_o   (io_wr),
		.io_rd_o   (io_rd),
		.io_wdata_o(io_wdata)
	);

	tcc_timer16 i_dut (
		.clk_sys_i          (clk_sys_i),
		.rst_i              (rst_i),
		.io_addr_i          (io_addr),
		.io_wr_i            (io_wr),
		.io_rd_i            (io_rd),
		.io_wdata_i         (io_wdata),
		.io_rdata_o         (io_rdata),
		.capture_irq_ack_i  (cap_ack),
		.overflow_irq_ack_i (ovf_ack),
		.prescale_taps_i    (taps),
		.external_tick_pin_i(ext_pin),
		.capture_pin_i      (cap_pin),
		.comparator_out_i   (cmp_out),
		.capture_irq_o      (cap_irq),
		.overflow_irq_o     (ovf_irq),
		.top_o              (top),
		.bottom_o           (bottom)
	);

	initial clk_sys_i = 1'b0;
	always #5 clk_sys_i = ~clk_sys_i;

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// The whole sequence needs a few hundred cycles; this ceiling only catches hangs.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("ERROR %0t: timeout", $time);
			test_done();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
		i_cpu.wr(lo + 4'h1, d[15:8]);
		i_cpu.wr(lo, d[7:0]);
	endtask

	task automatic rd16(input logic [3:0] lo, output logic [15:0] d);
		i_cpu.rd(lo, d[7:0]);
		i_cpu.rd(lo + 4'h1, d[15:8]);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge clk_sys_i);
			taps = 4'h1;
			@(negedge clk_sys_i);
			taps = 4'h0;
		end
	endtask

	task automatic set_cap(input logic val, input int n);
		@(negedge clk_sys_i);
		cap_pin = val;
		repeat (n) @(negedge clk_sys_i);
	endtask

	task automatic ext_pulse();
		@(negedge clk_sys_i);
		ext_pin = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		ext_pin = 1'b0;
		repeat (3) @(negedge clk_sys_i);
	endtask

	task automatic pulse_ack();
		@(negedge clk_sys_i);
		cap_ack = 1'b1;
		ovf_ack = 1'b1;
		@(negedge clk_sys_i);
		cap_ack = 1'b0;
		ovf_ack = 1'b0;
	endtask

	initial begin
		rst_i = 1'b1;
		cap_ack = 1'b0;
		ovf_ack = 1'b0;
		taps = 4'h0;
		ext_pin = 1'b0;
		cap_pin = 1'b0;
		cmp_out = 1'b0;
		mismatches = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (8) @(negedge clk_sys_i);
		rst_i = 1'b0;
		rd16(tcc_pkg::ADDR_CNT_LO, v);
		chk(v, 16'h0000);
		rd16(tcc_pkg::ADDR_CAP_LO, v);
		chk(v, 16'h0000);
		chk({15'h0000, bottom}, 16'h0001);
		chk({15'h0000, top}, 16'h0000);
		// One high byte serves two low writes while no tick source is chosen.
		i_cpu.wr(tcc_pkg::ADDR_CNT_HI, 8'hAB);
		i_cpu.wr(tcc_pkg::ADDR_CNT_LO, 8'h12);
		i_cpu.wr(tcc_pkg::ADDR_CMPA_LO, 8'h34);
		i_cpu.rd(tcc_pkg::ADDR_CMPA_HI, b);
		chk({8'h00, b}, 16'h00AB);
		ticks(2);
		rd16(tcc_pkg::ADDR_CNT_LO, v);
		chk(v, 16'hAB12);
		wr16(tcc_pkg::ADDR_CAP_LO, 16'h7777);
		rd16(tcc_pkg::ADDR_CAP_LO, v);
		chk(v, 16'h0000);
		// Mode 5 counts up to 0x00FF on prescaler tap 0.
		i_cpu.wr(tcc_pkg::ADDR_CTRL_A, 8'h01);
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h0A);
		i_cpu.wr(tcc_pkg::ADDR_MASK, 8'h21);
		wr16(tcc_pkg::ADDR_CNT_LO, 16'h00FE);
		ticks(1);
		chk({15'h0000, top}, 16'h0001);
		rd16(tcc_pkg::ADDR_CNT_LO, v);
		chk(v, 16'h00FF);
		ticks(1);
		chk({15'h0000, bottom}, 16'h0001);
		chk({15'h0000, ovf_irq}, 16'h0001);
		i_cpu.rd(tcc_pkg::ADDR_FLAGS, b);
		chk({15'h0000, b[0]}, 16'h0001);
		pulse_ack();
		chk({15'h0000, ovf_irq}, 16'h0000);
		// Mode 1 turns at 0x00FF and steps down.
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h02);
		wr16(tcc_pkg::ADDR_CNT_LO, 16'h00FE);
		ticks(2);
		rd16(tcc_pkg::ADDR_CNT_LO, v);
		chk(v, 16'h00FE);
		// A low write landing on a tick wins.
		i_cpu.wr(tcc_pkg::ADDR_CNT_HI, 8'h12);
		fork
			i_cpu.wr(tcc_pkg::ADDR_CNT_LO, 8'h40);
			ticks(1);
		join
		rd16(tcc_pkg::ADDR_CNT_LO, v);
		chk(v, 16'h1240);
		// Rising-edge capture from the pin, counter stopped.
		i_cpu.wr(tcc_pkg::ADDR_CTRL_A, 8'h00);
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h40);
		wr16(tcc_pkg::ADDR_CNT_LO, 16'h1234);
		set_cap(1'b1, 5);
		chk({15'h0000, cap_irq}, 16'h0001);
		rd16(tcc_pkg::ADDR_CAP_LO, v);
		chk(v, 16'h1234);
		i_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
		chk({15'h0000, cap_irq}, 16'h0000);
		wr16(tcc_pkg::ADDR_CNT_LO, 16'h5678);
		set_cap(1'b0, 6);
		chk({15'h0000, cap_irq}, 16'h0000);
		set_cap(1'b1, 5);
		pulse_ack();
		chk({15'h0000, cap_irq}, 16'h0000);
		// Filter on: a three-sample glitch is dropped, a real edge arrives late.
		// The filter must settle low first, or switching it in shows a false rising edge.
		set_cap(1'b0, 8);
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'hC0);
		set_cap(1'b1, 2);
		set_cap(1'b0, 8);
		chk({15'h0000, cap_irq}, 16'h0000);
		set_cap(1'b1, 6);
		chk({15'h0000, cap_irq}, 16'h0000);
		@(negedge clk_sys_i);
		chk({15'h0000, cap_irq}, 16'h0001);
		// Comparator routed in place of the pin; flag cleared after the switch.
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h40);
		i_cpu.wr(tcc_pkg::ADDR_ACMP, 8'h01);
		i_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
		wr16(tcc_pkg::ADDR_CNT_LO, 16'h0BAD);
		set_cap(1'b0, 3);
		set_cap(1'b1, 5);
		chk({15'h0000, cap_irq}, 16'h0000);
		@(negedge clk_sys_i);
		cmp_out = 1'b1;
		repeat (5) @(negedge clk_sys_i);
		chk({15'h0000, cap_irq}, 16'h0001);
		rd16(tcc_pkg::ADDR_CAP_LO, v);
		chk(v, 16'h0BAD);
		i_cpu.wr(tcc_pkg::ADDR_ACMP, 8'h00);
		i_cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
		// Mode 12 uses the capture register as top: writable, no captures.
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h5A);
		wr16(tcc_pkg::ADDR_CAP_LO, 16'h0005);
		rd16(tcc_pkg::ADDR_CAP_LO, v);
		chk(v, 16'h0005);
		wr16(tcc_pkg::ADDR_CNT_LO, 16'h0004);
		ticks(1);
		chk({15'h0000, top}, 16'h0001);
		set_cap(1'b0, 3);
		set_cap(1'b1, 6);
		chk({15'h0000, cap_irq}, 16'h0000);
		// External pin as tick source: two rising edges, then one falling edge.
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h07);
		wr16(tcc_pkg::ADDR_CNT_LO, 16'h0010);
		ext_pulse();
		ext_pulse();
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h06);
		ext_pulse();
		rd16(tcc_pkg::ADDR_CNT_LO, v);
		chk(v, 16'h0013);
		// Retrigger: a capture event forces top while the count is elsewhere.
		i_cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h60);
		wr16(tcc_pkg::ADDR_CNT_LO, 16'h0100);
		set_cap(1'b0, 4);
		chk({15'h0000, top}, 16'h0000);
		saw = 1'b0;
		cap_pin = 1'b1;
		repeat (8) begin
			@(negedge clk_sys_i);
			if (top === 1'b1) begin
				saw = 1'b1;
			end
		end
		chk({15'h0000, saw}, 16'h0001);
		test_done();
	end
endmodule
